/* design/xb_alloc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xb_params.svh"
module xb_alloc #(
    parameter int NP = `XB_NXP,
    parameter int NF = `XB_NF,
    parameter int FW = `XB_FW,
    parameter int PW = `XB_PW
) (
    input wire logic [NF-1:0] req,
    input wire logic [NP-1:0] taken_in,
    output logic [NP-1:0] pin_used,
    output logic [NP*FW-1:0] pin_func,
    output logic [NF-1:0] func_ok,
    output logic [NF*PW-1:0] func_pin
);
    logic [NP-1:0] taken;
    logic found;

    // Functions are visited in priority order; each takes the lowest free pin.
    always_comb
    begin
        taken = taken_in;
        pin_used = '0;
        pin_func = '0;
        func_ok = '0;
        func_pin = '0;
        found = 1'b0;
        for (int f = 0; f < NF; f++)
        begin
            found = 1'b0;
            for (int p = 0; p < NP; p++)
            begin
                if (req[f] && !found && !taken[p]) // R1
                begin
                    found = 1'b1;
                    taken[p] = 1'b1; // R3
                    pin_used[p] = 1'b1;
                    pin_func[p*FW +: FW] = FW'(f);
                    func_pin[f*PW +: PW] = PW'(p);
                    func_ok[f] = 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/xb_pin_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module xb_pin_cell (
    input wire logic digital,
    input wire logic push_pull,
    input wire logic force_od,
    input wire logic xbar_en,
    input wire logic want,
    input wire logic val,
    input wire logic pull_dis,
    input wire logic pad_in,
    output logic oe,
    output logic out,
    output logic pull_on,
    output logic rx_en,
    output logic rd
);
    logic drive;
    logic od;

    always_comb
    begin
        drive = digital & xbar_en & want; // R11 R17 R18
        od = force_od | ~push_pull; // R12 R13
        oe = drive & (od ? ~val : 1'b1);
        out = drive & val;
        // Pullup drops whenever the pin drives low, to save power.
        pull_on = digital & od & ~pull_dis & ~(oe & ~out); // R14 R15
        rx_en = digital; // R10 R11
        rd = digital ? pad_in : 1'b1; // R9
    end
endmodule
`default_nettype wire

/* design/xb_priority_pin_crossbar.sv */
// Contract
// R1 - Each selected function takes the lowest unassigned pin, in fixed priority order.
// R2 - Serial transmit sits on P0.4 and receive on P0.5, outside the search.
// R3 - A pin already given to a function is passed over for the next one.
// R4 - Pins with their skip bit set count as taken.
// R5 - Only P0.0 to P2.3 go to the crossbar; all pins do GPIO or analog.
// R6 - Two-wire bus claims both pins; serial port claims both pins.
// R7 - Unclaimed pins remain ordinary GPIO after the placed functions.
// R8 - Slave select is routed only in 4-wire SPI mode.
// R9 - Port read returns the real pin level whatever the routing; the code returns 1 for analog pins instead.
// R10 - Input mode 1 is digital, 0 analog; reset leaves all pins digital.
// R11 - Analog pins lose pullup, output driver and input receiver.
// R12 - Output mode bit picks open-drain or push-pull, for peripheral pins too.
// R13 - Two-wire bus pins always drive open-drain.
// R14 - Pullup disable at 0 gives open-drain pins a pullup; push-pull unaffected.
// R15 - Pullup is off on any pin driving low.
// R16 - Matrix enable at 1 turns on routing from both route selects.
// R17 - With the matrix disabled every pin is a plain input.
// R18 - With the matrix disabled all output drivers are off.
// R19 - Software sets input, output, skip, routing, then enables the matrix last.
// R20 - Software skips pins used outside the crossbar, such as crystal pins.
// R21 - Pins form three byte ports and a 5-bit port, each with controls.
// R22 - Mapping is recomputed every cycle and takes effect at the next edge.
`timescale 1ns/1ps
`default_nettype none
`include "xb_params.svh"
module xb_priority_pin_crossbar
    import xb_pkg::*;
#(
    parameter int NP = `XB_NP,
    parameter int NXP = `XB_NXP,
    parameter int NF = `XB_NF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire xb_route_a_t route_select_a,
    input wire xb_route_b_t route_select_b,
    input wire logic [1:0] slave_select_mode,
    input wire xb_port_vec_t pin_input_mode,
    input wire xb_port_vec_t pin_output_mode,
    input wire xb_port_vec_t pin_skip_mask,
    input wire xb_port_vec_t port_latch,
    input wire xb_periph_t periph_drv,
    input wire logic uart_tx,
    input wire logic [NP-1:0] pad_in,
    output logic [NP-1:0] pad_out,
    output logic [NP-1:0] pad_oe,
    output logic [NP-1:0] pad_pullup_en,
    output logic [NP-1:0] pad_rx_en,
    output logic [NP-1:0] port_read,
    output logic [NF-1:0] periph_in,
    output logic uart_rx,
    output logic [NF-1:0] func_placed,
    output logic [NXP-1:0] pin_assigned
);
    localparam int FW = `XB_FW;
    localparam int PW = `XB_PW;

    logic [NP-1:0] in_f;
    logic [NP-1:0] pp_f;
    logic [NP-1:0] skip_f;
    logic [NP-1:0] latch_f;
    logic xb_en;
    logic uart_on;
    logic four_wire;
    logic [NF-1:0] req;
    logic [NXP-1:0] taken0;
    logic [NXP-1:0] pin_used;
    logic [NXP*FW-1:0] pin_func;
    logic [NF-1:0] func_ok;
    logic [NF*PW-1:0] func_pin;
    logic [FW-1:0] fsel;
    logic [NP-1:0] want_n;
    logic [NP-1:0] val_n;
    logic [NP-1:0] fo_n;
    logic [NP-1:0] pad_out_nxt;
    logic [NP-1:0] pad_oe_nxt;
    logic [NP-1:0] pullup_nxt;
    logic [NP-1:0] rx_en_nxt;
    logic [NP-1:0] read_nxt;
    logic [NF-1:0] fin_nxt;
    logic urx_nxt;
    logic [NF-1:0] placed_nxt;
    logic [NXP-1:0] assigned_nxt;
    logic [NP-1:0] pad_out_r;
    logic [NP-1:0] pad_oe_r;
    logic [NP-1:0] pullup_r;
    logic [NP-1:0] rx_en_r;
    logic [NP-1:0] read_r;
    logic [NF-1:0] fin_r;
    logic urx_r;
    logic [NF-1:0] placed_r;
    logic [NXP-1:0] assigned_r;

    // Requests in priority order; one enable bit may claim several pins.
    function automatic logic [NF-1:0] req_decode(
        input xb_route_a_t ra,
        input xb_route_b_t rb,
        input logic fw
    );
        logic [NF-1:0] r;
        r = '0;
        r[`XB_F_SCK] = ra.spi_en;
        r[`XB_F_MISO] = ra.spi_en;
        r[`XB_F_MOSI] = ra.spi_en;
        r[`XB_F_NSS] = ra.spi_en & fw; // R8
        r[`XB_F_SDA] = ra.smbus_en; // R6
        r[`XB_F_SCL] = ra.smbus_en; // R6
        r[`XB_F_CP0] = ra.cp0_en;
        r[`XB_F_CP0A] = ra.cp0_async_en;
        r[`XB_F_CP1] = ra.cp1_en;
        r[`XB_F_CP1A] = ra.cp1_async_en;
        r[`XB_F_SYSCK] = ra.sysclk_en;
        for (int i = 0; i < `XB_NCEX; i++)
        begin
            r[`XB_F_CEX0 + i] = (rb.pca_sel > 3'(i));
        end
        r[`XB_F_ECI] = rb.eci_en;
        r[`XB_F_T0] = rb.t0_en;
        r[`XB_F_T1] = rb.t1_en;
        return r;
    endfunction

    function automatic logic is_smbus(input logic [FW-1:0] f);
        return (f == FW'(`XB_F_SDA)) || (f == FW'(`XB_F_SCL));
    endfunction

    always_comb
    begin
        in_f = pin_input_mode; // R21
        pp_f = pin_output_mode;
        skip_f = pin_skip_mask;
        latch_f = port_latch;
        xb_en = route_select_b.matrix_enable; // R16
        uart_on = route_select_a.uart_en;
        four_wire = slave_select_mode[`XB_NSS_4W_BIT];
        req = req_decode(route_select_a, route_select_b, four_wire);
        taken0 = skip_f[NXP-1:0]; // R4 R5
        if (uart_on)
        begin
            taken0[`XB_TX_PIN] = 1'b1; // R2 R6
            taken0[`XB_RX_PIN] = 1'b1;
        end
    end

    xb_alloc #(
        .NP(NXP),
        .NF(NF),
        .FW(FW),
        .PW(PW)
    ) u_alloc (
        .req(req),
        .taken_in(taken0),
        .pin_used(pin_used),
        .pin_func(pin_func),
        .func_ok(func_ok),
        .func_pin(func_pin)
    );

    // Pins default to their port latch, so leftovers act as GPIO.
    always_comb
    begin
        want_n = '1; // R7
        val_n = latch_f;
        fo_n = '0;
        fsel = '0;
        for (int p = 0; p < NXP; p++)
        begin
            fsel = pin_func[p*FW +: FW];
            if (uart_on && p == `XB_TX_PIN)
            begin
                val_n[p] = uart_tx; // R2
            end
            else if (uart_on && p == `XB_RX_PIN)
            begin
                want_n[p] = 1'b0; // R2
                val_n[p] = 1'b1;
            end
            else if (pin_used[p])
            begin
                val_n[p] = periph_drv.val[fsel];
                want_n[p] = periph_drv.oe[fsel];
                // The bus only forces open-drain while it is really routed out.
                fo_n[p] = xb_en & is_smbus(fsel); // R13 R17
            end
        end
    end

    generate
        for (genvar g = 0; g < NP; g++)
        begin : g_cell
            xb_pin_cell u_cell (
                .digital(in_f[g]),
                .push_pull(pp_f[g]),
                .force_od(fo_n[g]),
                .xbar_en(xb_en),
                .want(want_n[g]),
                .val(val_n[g]),
                .pull_dis(route_select_b.pullup_disable),
                .pad_in(pad_in[g]),
                .oe(pad_oe_nxt[g]),
                .out(pad_out_nxt[g]),
                .pull_on(pullup_nxt[g]),
                .rx_en(rx_en_nxt[g]),
                .rd(read_nxt[g])
            );
        end
    endgenerate

    // Unplaced functions see an idle high level, as on an undriven pullup line.
    always_comb
    begin
        fin_nxt = '1;
        for (int f = 0; f < NF; f++)
        begin
            if (xb_en && func_ok[f])
            begin
                fin_nxt[f] = read_nxt[func_pin[f*PW +: PW]];
            end
        end
        urx_nxt = (xb_en && uart_on) ? read_nxt[`XB_RX_PIN] : 1'b1;
        placed_nxt = xb_en ? func_ok : '0;
        assigned_nxt = xb_en ? pin_used : '0;
    end

    // Registering every output costs one cycle of latency but keeps pins glitch free.
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pad_out_r <= `XB_RST_ZERO;
            pad_oe_r <= `XB_RST_ZERO;
            pullup_r <= `XB_RST_ZERO;
            rx_en_r <= `XB_RST_ONES; // R10
            read_r <= `XB_RST_ONES;
            fin_r <= `XB_FIN_IDLE;
            urx_r <= 1'b1;
            placed_r <= '0;
            assigned_r <= '0;
        end
        else
        begin
            pad_out_r <= pad_out_nxt; // R22
            pad_oe_r <= pad_oe_nxt;
            pullup_r <= pullup_nxt;
            rx_en_r <= rx_en_nxt;
            read_r <= read_nxt; // R9
            fin_r <= fin_nxt;
            urx_r <= urx_nxt;
            placed_r <= placed_nxt;
            assigned_r <= assigned_nxt;
        end
    end

    assign pad_out = pad_out_r;
    assign pad_oe = pad_oe_r;
    assign pad_pullup_en = pullup_r;
    assign pad_rx_en = rx_en_r;
    assign port_read = read_r;
    assign periph_in = fin_r;
    assign uart_rx = urx_r;
    assign func_placed = placed_r;
    assign pin_assigned = assigned_r;

    logic [NXP-1:0] skip_chk;
    logic [NP-1:0] read_exp;
    logic [NP-1:0] pp_chk;
    logic tx_case;
    logic hi_case;

    always_comb
    begin
        skip_chk = skip_f[NXP-1:0];
        if (uart_on)
        begin
            skip_chk[`XB_TX_PIN] = 1'b0;
            skip_chk[`XB_RX_PIN] = 1'b0;
        end
        read_exp = (in_f & pad_in) | ~in_f;
        pp_chk = pp_f & ~fo_n;
        tx_case = uart_on && xb_en && in_f[`XB_TX_PIN];
        hi_case = xb_en && in_f[NXP] && pp_f[NXP];
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_uart_tx_fixed: assert property (tx_case |=> pad_out_r[`XB_TX_PIN] == $past(uart_tx)) // R2
    else $error("transmit pin does not follow serial transmit");
    a_skip_unused: assert property (1'b1 |=> (assigned_r & $past(skip_chk)) == '0) // R4
    else $error("skipped pin was assigned");
    a_upper_gpio: assert property (hi_case |=> pad_out_r[NXP] == $past(latch_f[NXP])) // R5
    else $error("pin above crossbar range does not follow its latch");
    a_nss_mode: assert property (!four_wire |=> !func_placed[`XB_F_NSS]) // R8
    else $error("slave select placed outside 4-wire mode");
    a_read_pin: assert property (1'b1 |=> port_read == $past(read_exp)) // R9
    else $error("port read differs from pin level");
    a_analog_quiet: assert property (1'b1 |=> ((pad_oe | pad_pullup_en | pad_rx_en) & ~$past(in_f)) == '0) // R11
    else $error("analog pin has digital circuitry on");
    a_pp_no_pullup: assert property (1'b1 |=> (pad_pullup_en & $past(pp_chk)) == '0) // R14
    else $error("pullup on push-pull pin");
    a_low_no_pullup: assert property ((pad_pullup_en & pad_oe & ~pad_out) == '0) // R15
    else $error("pullup on while driving low");
    a_off_no_drive: assert property (!xb_en |=> pad_oe == '0) // R17 R18
    else $error("driver on with matrix disabled");

    c_spi_placed: cover property (xb_en && route_select_a.spi_en ##1 func_placed[`XB_F_SCK]);
    c_smbus_placed: cover property (xb_en ##1 func_placed[`XB_F_SDA] && func_placed[`XB_F_SCL]);
    c_uart_skip: cover property (tx_case && skip_f[`XB_TX_PIN]);
endmodule
`default_nettype wire

/* include/xb_params.svh */
`ifndef XB_PARAMS_SVH
`define XB_PARAMS_SVH
`define XB_NP 29
`define XB_NXP 20
`define XB_NF 19
`define XB_FW 5
`define XB_PW 5
`define XB_TX_PIN 4
`define XB_RX_PIN 5
`define XB_F_SCK 0
`define XB_F_MISO 1
`define XB_F_MOSI 2
`define XB_F_NSS 3
`define XB_F_SDA 4
`define XB_F_SCL 5
`define XB_F_CP0 6
`define XB_F_CP0A 7
`define XB_F_CP1 8
`define XB_F_CP1A 9
`define XB_F_SYSCK 10
`define XB_F_CEX0 11
`define XB_F_ECI 16
`define XB_F_T0 17
`define XB_F_T1 18
`define XB_NCEX 5
`define XB_NSS_4W_BIT 1
`define XB_RST_ZERO 29'h0
`define XB_RST_ONES 29'h1FFFFFFF
`define XB_FIN_IDLE 19'h7FFFF
`endif

/* include/xb_pkg.sv */
`include "xb_params.svh"
package xb_pkg;
    typedef struct packed {
        logic cp1_async_en;
        logic cp1_en;
        logic cp0_async_en;
        logic cp0_en;
        logic sysclk_en;
        logic smbus_en;
        logic spi_en;
        logic uart_en;
    } xb_route_a_t;
    typedef struct packed {
        logic pullup_disable;
        logic matrix_enable;
        logic t1_en;
        logic t0_en;
        logic eci_en;
        logic [2:0] pca_sel;
    } xb_route_b_t;
    typedef struct packed {
        logic [4:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } xb_port_vec_t;
    typedef struct packed {
        logic [`XB_NF-1:0] val;
        logic [`XB_NF-1:0] oe;
    } xb_periph_t;
endpackage

/* testbench/tb_priority_pin_crossbar.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_priority_pin_crossbar import xb_pkg::*;;
    typedef struct packed {
        logic [28:0] oe, out, pu, rd, rx;
        logic [18:0] pl, fi;
        logic [19:0] asg;
        logic ur, en;
    } xb_exp_t;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    xb_route_a_t ra;
    xb_route_b_t rb;
    logic [1:0] ssm;
    xb_port_vec_t imode, omode, skip, latch;
    xb_periph_t pdrv;
    logic utx;
    logic [28:0] ext_en, ext_val, pad_in, pad_out, pad_oe, pad_pu, pad_rx, port_read;
    logic [18:0] periph_in, func_placed;
    logic [19:0] pin_assigned;
    logic uart_rx;
    int bad_count = 0;
    int num_checks = 0;
    int seed = 44330;
    xb_exp_t exp_q[$];
    xb_exp_t cur;
    always #2 sys_clk = ~sys_clk;
    xb_priority_pin_crossbar uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .route_select_a(ra), .route_select_b(rb),
        .slave_select_mode(ssm), .pin_input_mode(imode), .pin_output_mode(omode),
        .pin_skip_mask(skip), .port_latch(latch), .periph_drv(pdrv), .uart_tx(utx),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pu),
        .pad_rx_en(pad_rx), .port_read(port_read), .periph_in(periph_in), .uart_rx(uart_rx),
        .func_placed(func_placed), .pin_assigned(pin_assigned));
    xb_pad_partner pads (
        .sys_clk(sys_clk), .rst_b(rst_b), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup_en(pad_pu), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    task automatic cmp_pins(string nm, logic [28:0] e, logic [28:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_func(string nm, logic [18:0] e, logic [18:0] g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmp_bit(string nm, logic e, logic g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Inputs were set at this falling edge; the note lands one rising edge later.
    task automatic step();
        xb_exp_t e;
        logic [18:0] req;
        logic [19:0] taken;
        int own[29];
        int p;
        logic od, want, v, dig;
        #1;
        e = '0;
        e.fi = 19'h7FFFF;
        e.en = rb.matrix_enable;
        req = {rb.t1_en, rb.t0_en, rb.eci_en, 5'h0, ra.sysclk_en, ra.cp1_async_en, ra.cp1_en,
               ra.cp0_async_en, ra.cp0_en, {2{ra.smbus_en}}, ra.spi_en & ssm[1], {3{ra.spi_en}}};
        for (int k = 0; k < 5; k++)
            req[11 + k] = (k < rb.pca_sel);
        taken = skip[19:0];
        if (ra.uart_en)
            taken[5:4] = 2'h3;
        for (int k = 0; k < 29; k++)
            own[k] = -1;
        p = 0;
        for (int f = 0; f < 19; f++)
        begin
            while (p < 20 && taken[p])
                p++;
            if (req[f] && p < 20 && e.en)
            begin
                own[p] = f;
                e.pl[f] = 1'b1;
                e.asg[p] = 1'b1;
                p++;
            end
        end
        for (int k = 0; k < 29; k++)
        begin
            dig = imode[k];
            od = ~omode[k];
            want = 1'b1;
            v = latch[k];
            if (own[k] >= 0)
            begin
                want = pdrv.oe[own[k]];
                v = pdrv.val[own[k]];
                od = od | (own[k] == 4) | (own[k] == 5);
                e.fi[own[k]] = pad_in[k];
            end
            else if (ra.uart_en && k == 4)
                v = utx;
            else if (ra.uart_en && k == 5)
                want = 1'b0;
            want = want & dig & e.en;
            e.oe[k] = want & (~od | ~v);
            e.out[k] = want & v;
            e.pu[k] = dig & od & ~rb.pullup_disable & ~(e.oe[k] & ~e.out[k]);
            e.rd[k] = dig ? pad_in[k] : 1'b1;
            e.rx[k] = dig;
        end
        e.ur = (e.en & ra.uart_en) ? pad_in[5] : 1'b1;
        exp_q.push_back(e);
        @(negedge sys_clk);
    endtask
    // Analog pins are always skipped too, as configuring software is expected to do.
    task automatic rnd_cfg();
        ra = 8'($random(seed));
        rb = 8'($random(seed));
        ssm = 2'($random(seed));
        skip = 29'($random(seed) & $random(seed));
        imode = ~(skip & 29'($random(seed))) | 29'h30;
        omode = 29'($random(seed));
        latch = 29'($random(seed));
        pdrv = {19'($random(seed)), 19'($random(seed))};
        utx = 1'($random(seed));
        ext_en = 29'($random(seed));
        ext_val = 29'($random(seed));
    endtask
    always @(posedge sys_clk)
    begin
        #1;
        if (exp_q.size() > 0)
        begin
            cur = exp_q.pop_front();
            cmp_pins("pad_oe", cur.oe, pad_oe);
            cmp_pins("pad_out", cur.out, pad_out);
            cmp_pins("pad_rx_en", cur.rx, pad_rx);
            cmp_pins("port_read", cur.rd, port_read);
            cmp_func("func_placed", cur.pl, func_placed);
            cmp_func("periph_in", cur.fi, periph_in);
            cmp_bit("uart_rx", cur.ur, uart_rx);
            cmp_pins("pad_pullup_en", cur.pu, pad_pu);
            cmp_pins("pin_assigned", {9'h0, cur.asg}, {9'h0, pin_assigned});
        end
    end
    initial
    begin
        #4000;
        bad_count++;
        final_report();
    end
    initial
    begin
        ra = 8'h00;
        rb = 8'h00;
        ssm = 2'h0;
        imode = 29'h1FFFFFFF;
        omode = 29'h0;
        skip = 29'h0;
        latch = 29'h1FFFFFFF;
        pdrv = {19'h2A5A5, 19'h7FFFF};
        utx = 1'b1;
        ext_en = 29'h0;
        ext_val = 29'h0;
        repeat (10) @(negedge sys_clk);
        cmp_pins("pad_oe", 29'h0, pad_oe);
        cmp_pins("pad_rx_en", 29'h1FFFFFFF, pad_rx);
        cmp_func("func_placed", 19'h0, func_placed);
        cmp_func("periph_in", 19'h7FFFF, periph_in);
        cmp_bit("uart_rx", 1'b1, uart_rx);
        repeat (10) @(negedge sys_clk);
        rst_b = 1'b1;
        ra = 8'hFF;
        rb = 8'h1D;
        step();
        ra = 8'h02;
        rb = 8'h40;
        step();
        ssm = 2'h2;
        step();
        imode = 29'h1FFFFFF3;
        skip = 29'h0C;
        ra = 8'hFF;
        rb = 8'h3D;
        step();
        rb = 8'h7D;
        step();
        omode = 29'h1FFFFFFF;
        ra = 8'h07;
        for (int s = 0; s < 8; s++)
        begin
            rb = {5'h0F, 3'(s)};
            step();
        end
        repeat (400)
        begin
            rnd_cfg();
            step();
        end
        repeat (3) @(posedge sys_clk);
        final_report();
    end
endmodule
`default_nettype wire

/* testbench/xb_pad_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module xb_pad_partner (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [28:0] pad_out,
    input wire logic [28:0] pad_oe,
    input wire logic [28:0] pad_pullup_en,
    input wire logic [28:0] ext_en,
    input wire logic [28:0] ext_val,
    output logic [28:0] pad_in
);
    // An undriven pin without pullup toggles, so a stale level can never pass for a match.
    logic [28:0] float_r;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            float_r <= 29'h0AAAAAAA;
        else
            float_r <= ~float_r;
    end
    // External drivers only act where the block has let go of the pin.
    always_comb
    begin
        for (int k = 0; k < 29; k++)
            pad_in[k] = pad_oe[k] ? pad_out[k] :
                        (ext_en[k] ? ext_val[k] : (pad_pullup_en[k] | float_r[k]));
    end
endmodule
`default_nettype wire
